// ---- mac_monitor_ctrl.sv ----
// Converter sequencing, register file and CPU thermal poll control
`timescale 1ns/100ps
`default_nettype none
`include "mac_defines.svh"

// Overview of operation
// - Bypass each voltage attenuator separately from bits 7:4 of 0x7d.
// - Bit 6 of 0x73 converts only the selected channel.
// - In single-channel mode with averaging off a fresh reading arrives every 0.7 ms.
// - Channel select comes from bits 7:4 of 0x55, codes 0 to 9.
// - Conversion codes are unsigned 10 bits, 0 to 1023.
// - Local, two remote and four digital CPU temperature channels exist.
// - The block initiates every CPU thermal poll itself.
// - CPU readings are kept in relative format, never made absolute.
// - CPUs are polled only while bit 4 of 0x40 is set.
// - Bits 7:6 of 0x88 give how many CPUs to poll.
// - Each CPU is addressed separately by its own bus address.
// - Domain count bits: 0x36 bit 3, then 0x88 bits 5, 4, 3.
// - Only the hottest domain of a CPU is stored.
// - CPU reading channels 0 to 3 use addresses 0x30 to 0x33.
// - Sixteen conversions are averaged unless averaging is switched off.
module mac_monitor_ctrl #(
    parameter int CONV_CYCLES = `MAC_CONV_CYCLES,
    parameter int NUM_CHAN    = `MAC_NUM_CHAN,
    parameter int MEAN_COUNT  = `MAC_MEAN_COUNT
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Register access
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output var  logic [7:0] reg_rdata,
    // Converter
    output var  logic       adc_start,
    output var  logic [3:0] adc_channel,
    output var  logic [3:0] atten_bypass,
    input  wire logic       adc_done,
    input  wire logic [9:0] adc_code,
    // CPU thermal bus engine
    output var  logic       poll_req,
    output var  logic [7:0] poll_addr,
    output var  logic       poll_domain,
    input  wire logic       poll_done,
    input  wire logic [7:0] poll_temp
);
    localparam int TW = $clog2(CONV_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] cfg1_reg, cfg2_reg, cfg4_reg, fan1_reg, cnt_reg, pcfg_reg;
    mac_pkg::mac_chan_t sel_reg;
    logic [7:0] cpu_rd [0:3];
    mac_pkg::mac_code_t rd_mem [0:NUM_CHAN-1];
    logic [7:0] rd_mux;

    wire wr_cfg1 = reg_wr && (reg_addr == `MAC_OFS_CFG1);
    wire wr_cfg2 = reg_wr && (reg_addr == `MAC_OFS_CFG2);
    wire wr_cfg4 = reg_wr && (reg_addr == `MAC_OFS_CFG4);
    wire wr_fan1 = reg_wr && (reg_addr == `MAC_OFS_FAN1_MIN_HI);
    wire wr_cnt  = reg_wr && (reg_addr == `MAC_OFS_CPU_COUNT);
    wire wr_pcfg = reg_wr && (reg_addr == `MAC_OFS_CPU_CFG);

    wire       single_mode = cfg2_reg[`MAC_BIT_SINGLE];
    wire       averaging_off = cfg2_reg[`MAC_BIT_AVERAGING_OFF];
    wire       cpu_en      = cfg1_reg[`MAC_BIT_CPU_EN];
    wire [3:0] sel_code    = reg_wdata[`MAC_SEL_HI:`MAC_SEL_LO];
    wire       sel_ok      = (sel_code <= `MAC_SEL_MAX);
    wire [1:0] cpu_last    = cnt_reg[`MAC_CNT_HI:`MAC_CNT_LO];
    wire [3:0] dom_bits    = {cnt_reg[`MAC_DOM_CPU3], cnt_reg[`MAC_DOM_CPU2],
                              cnt_reg[`MAC_DOM_CPU1], pcfg_reg[`MAC_BIT_CPU0_DOM]};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg1_reg <= `MAC_REG_RESET;
            cfg2_reg <= `MAC_REG_RESET;
            cfg4_reg <= `MAC_REG_RESET;
            fan1_reg <= `MAC_REG_RESET;
            cnt_reg  <= `MAC_REG_RESET;
            pcfg_reg <= `MAC_REG_RESET;
        end else begin
            if (wr_cfg1) cfg1_reg <= reg_wdata;
            if (wr_cfg2) cfg2_reg <= reg_wdata;
            if (wr_cfg4) cfg4_reg <= reg_wdata;
            // Same byte also serves the fan 1 speed limit
            if (wr_fan1) fan1_reg <= reg_wdata;
            if (wr_cnt)  cnt_reg  <= reg_wdata;
            if (wr_pcfg) pcfg_reg <= reg_wdata;
        end
    end

    // Reserved codes would point at no input, so they leave the choice alone
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) sel_reg <= 4'h0;
        else if (wr_fan1 && sel_ok) sel_reg <= sel_code;
    end

    // Individual attenuator bypass, one bit per supply input
    assign atten_bypass = cfg4_reg[`MAC_BYPASS_HI:`MAC_BYPASS_LO];

    // Readings show the upper eight bits of the 10-bit code
    always_comb begin
        if (reg_addr == `MAC_OFS_CFG1) rd_mux = cfg1_reg;
        else if (reg_addr == `MAC_OFS_CFG2) rd_mux = cfg2_reg;
        else if (reg_addr == `MAC_OFS_CFG4) rd_mux = cfg4_reg;
        else if (reg_addr == `MAC_OFS_FAN1_MIN_HI) rd_mux = fan1_reg;
        else if (reg_addr == `MAC_OFS_CPU_COUNT) rd_mux = cnt_reg;
        else if (reg_addr == `MAC_OFS_CPU_CFG) rd_mux = pcfg_reg;
        else if (reg_addr == `MAC_OFS_CPU_RD0) rd_mux = cpu_rd[0];
        else if (reg_addr == `MAC_OFS_CPU_RD1) rd_mux = cpu_rd[1];
        else if (reg_addr == `MAC_OFS_CPU_RD2) rd_mux = cpu_rd[2];
        else if (reg_addr == `MAC_OFS_CPU_RD3) rd_mux = cpu_rd[3];
        else if (reg_addr == `MAC_OFS_RD_V25) rd_mux = rd_mem[0][9:2];
        else if (reg_addr == `MAC_OFS_RD_VCORE) rd_mux = rd_mem[1][9:2];
        else if (reg_addr == `MAC_OFS_RD_VOWN) rd_mux = rd_mem[2][9:2];
        else if (reg_addr == `MAC_OFS_RD_V5) rd_mux = rd_mem[3][9:2];
        else if (reg_addr == `MAC_OFS_RD_V12) rd_mux = rd_mem[4][9:2];
        else if (reg_addr == `MAC_OFS_RD_REMOTE1) rd_mux = rd_mem[5][9:2];
        else if (reg_addr == `MAC_OFS_RD_CPU_TERM) rd_mux = rd_mem[8][9:2];
        else if (reg_addr == `MAC_OFS_RD_CPU_CUR) rd_mux = rd_mem[9][9:2];
        else rd_mux = 8'h00;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) reg_rdata <= 8'h00;
        else if (reg_rd) reg_rdata <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencing
    logic [TW-1:0]      conv_cnt_reg;
    mac_pkg::mac_chan_t rr_idx_reg, rr_idx_next;
    logic               single_prev_reg, rr_conv_reg;
    mac_pkg::mac_chan_t sel_prev_reg;
    logic               mean_valid;
    mac_pkg::mac_code_t mean_value;

    wire conv_tick = (conv_cnt_reg == TW'(CONV_CYCLES - 1));
    wire [3:0] cur_chan = single_mode ? sel_reg : rr_idx_reg;
    wire mean_clear = (single_mode != single_prev_reg) || (sel_reg != sel_prev_reg);
    wire rr_step = mean_valid && rr_conv_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) conv_cnt_reg <= '0;
        else conv_cnt_reg <= conv_tick ? '0 : conv_cnt_reg + TW'(1);
    end

    // Held at the first channel during single mode, so the cycle restarts there
    always_comb begin
        if (single_mode) rr_idx_next = 4'h0;
        else if (rr_step && rr_idx_reg == 4'(NUM_CHAN - 1)) rr_idx_next = 4'h0;
        else if (rr_step) rr_idx_next = rr_idx_reg + 4'h1;
        else rr_idx_next = rr_idx_reg;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rr_idx_reg      <= 4'h0;
            single_prev_reg <= 1'b0;
            sel_prev_reg    <= 4'h0;
        end else begin
            rr_idx_reg      <= rr_idx_next;
            single_prev_reg <= single_mode;
            sel_prev_reg    <= sel_reg;
        end
    end

    // Converter must finish inside one period; a late result is taken as-is
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            adc_start   <= 1'b0;
            adc_channel <= 4'h0;
            rr_conv_reg <= 1'b0;
        end else begin
            adc_start <= conv_tick;
            if (conv_tick) adc_channel <= cur_chan;
            if (conv_tick) rr_conv_reg <= !single_mode;
        end
    end

    mac_averager #(.W(10), .N(MEAN_COUNT)) i_mac_averager (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .clear         (mean_clear),
        .averaging_off (averaging_off),
        .sample_valid  (adc_done),
        .sample        (adc_code),
        .result_valid  (mean_valid),
        .result        (mean_value)
    );

    // Local and remote diode channels share this array with the supplies
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CHAN; i++) rd_mem[i] <= 10'h000;
        end else if (mean_valid) begin
            rd_mem[adc_channel] <= mean_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU thermal polling
    mac_pkg::mac_poll_state_t st_reg, st_next;
    logic [1:0] cpu_reg, cpu_next;
    logic       dom_reg, dom_next;
    logic [7:0] hot_reg, hot_next;
    logic       rec_we;

    wire [7:0] hot_cand = (dom_reg && $signed(hot_reg) > $signed(poll_temp))
                          ? hot_reg : poll_temp;
    wire       more_dom = !dom_reg && dom_bits[cpu_reg];

    always_comb begin
        st_next  = st_reg;
        cpu_next = cpu_reg;
        dom_next = dom_reg;
        hot_next = hot_reg;
        rec_we   = 1'b0;
        case (st_reg)
            mac_pkg::P_IDLE: begin
                cpu_next = 2'd0;
                dom_next = 1'b0;
                if (cpu_en) st_next = mac_pkg::P_REQ;
            end
            mac_pkg::P_REQ: begin
                st_next = cpu_en ? mac_pkg::P_WAIT : mac_pkg::P_IDLE;
            end
            mac_pkg::P_WAIT: begin
                if (poll_done) begin
                    hot_next = hot_cand;
                    st_next  = mac_pkg::P_REQ;
                    if (more_dom) begin
                        dom_next = 1'b1;
                    end else begin
                        rec_we   = 1'b1;
                        dom_next = 1'b0;
                        cpu_next = cpu_reg + 2'd1;
                        if (cpu_reg == cpu_last) st_next = mac_pkg::P_IDLE;
                    end
                end
            end
            default: st_next = mac_pkg::P_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg  <= mac_pkg::P_IDLE;
            cpu_reg <= 2'd0;
            dom_reg <= 1'b0;
            hot_reg <= 8'h00;
        end else begin
            st_reg  <= st_next;
            cpu_reg <= cpu_next;
            dom_reg <= dom_next;
            hot_reg <= hot_next;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            poll_req    <= 1'b0;
            poll_addr   <= `MAC_CPU_ADDR_BASE;
            poll_domain <= 1'b0;
        end else begin
            poll_req <= (st_reg == mac_pkg::P_REQ) && cpu_en;
            if (st_reg == mac_pkg::P_REQ) begin
                poll_addr   <= `MAC_CPU_ADDR_BASE + {6'h00, cpu_reg};
                poll_domain <= dom_reg;
            end
        end
    end

    // Kept in relative format, as read from the CPU
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) cpu_rd[i] <= 8'h00;
        end else if (rec_we) begin
            cpu_rd[cpu_reg] <= hot_cand;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    int gap_cnt;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) gap_cnt <= 0;
        else gap_cnt <= adc_start ? 1 : gap_cnt + 1;
    end

    a_bypass_follow: assert property (@(posedge ref_clk) disable iff (rst)
        wr_cfg4 |=> atten_bypass == $past(reg_wdata[7:4]))
        else $error("attenuator bypass does not follow register");
    a_single_chan: assert property (@(posedge ref_clk) disable iff (rst)
        adc_start && $past(single_mode) |-> adc_channel == $past(sel_reg))
        else $error("single mode converted wrong channel");
    a_conv_period: assert property (@(posedge ref_clk) disable iff (rst)
        adc_start && gap_cnt != 0 |-> gap_cnt == CONV_CYCLES)
        else $error("conversion start spacing wrong");
    a_sel_reserved: assert property (@(posedge ref_clk) disable iff (rst)
        wr_fan1 && !sel_ok |=> $stable(sel_reg))
        else $error("reserved select code changed channel");
    a_sel_taken: assert property (@(posedge ref_clk) disable iff (rst)
        wr_fan1 && sel_ok |=> sel_reg == $past(sel_code))
        else $error("valid select code not taken");
    a_rr_restart: assert property (@(posedge ref_clk) disable iff (rst)
        single_mode |=> rr_idx_reg == 4'h0)
        else $error("sequence not restarted at first channel");
    a_poll_enable: assert property (@(posedge ref_clk) disable iff (rst)
        poll_req |-> $past(cpu_en))
        else $error("poll issued while CPU monitoring disabled");
    a_poll_addr: assert property (@(posedge ref_clk) disable iff (rst)
        poll_req |-> poll_addr == `MAC_CPU_ADDR_BASE + {6'h00, $past(cpu_reg)})
        else $error("poll address does not match CPU index");
    a_poll_count: assert property (@(posedge ref_clk) disable iff (rst)
        poll_req |-> $past(cpu_reg) <= $past(cpu_last))
        else $error("polled more CPUs than programmed");
    a_domain_cnt: assert property (@(posedge ref_clk) disable iff (rst)
        poll_req && poll_domain |-> $past(dom_bits[cpu_reg]))
        else $error("second domain polled on single-domain CPU");
    a_hottest_kept: assert property (@(posedge ref_clk) disable iff (rst)
        rec_we |=> $signed(cpu_rd[$past(cpu_reg)]) >= $signed($past(poll_temp)))
        else $error("stored CPU reading is not the hottest");

    c_single_conv: cover property (@(posedge ref_clk) disable iff (rst)
        adc_start && single_mode && averaging_off);
    c_rr_wrap: cover property (@(posedge ref_clk) disable iff (rst)
        mean_valid && rr_idx_reg == 4'(NUM_CHAN - 1));
    c_dual_dom: cover property (@(posedge ref_clk) disable iff (rst)
        poll_req && poll_domain);
    c_last_cpu: cover property (@(posedge ref_clk) disable iff (rst)
        rec_we && cpu_reg == 2'd3);

endmodule : mac_monitor_ctrl
`default_nettype wire

// ---- mac_defines.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef MAC_DEFINES_SVH
`define MAC_DEFINES_SVH

`define MAC_OFS_CFG1          8'h40
`define MAC_OFS_CFG2          8'h73
`define MAC_OFS_CFG4          8'h7d
`define MAC_OFS_FAN1_MIN_HI   8'h55
`define MAC_OFS_CPU_COUNT     8'h88
`define MAC_OFS_CPU_CFG       8'h36
`define MAC_OFS_CPU_RD0       8'h33
`define MAC_OFS_CPU_RD1       8'h1a
`define MAC_OFS_CPU_RD2       8'h1b
`define MAC_OFS_CPU_RD3       8'h1c
`define MAC_OFS_RD_CPU_CUR    8'h1d
`define MAC_OFS_RD_CPU_TERM   8'h1e
`define MAC_OFS_RD_V25        8'h20
`define MAC_OFS_RD_VCORE      8'h21
`define MAC_OFS_RD_VOWN       8'h22
`define MAC_OFS_RD_V5         8'h23
`define MAC_OFS_RD_V12        8'h24
`define MAC_OFS_RD_REMOTE1    8'h25

`define MAC_REG_RESET         8'h00

`define MAC_BIT_CPU_EN        4
`define MAC_BIT_AVERAGING_OFF 4
`define MAC_BIT_SINGLE        6
`define MAC_BIT_CPU0_DOM      3
`define MAC_BYPASS_HI         7
`define MAC_BYPASS_LO         4
`define MAC_SEL_HI            7
`define MAC_SEL_LO            4
`define MAC_CNT_HI            7
`define MAC_CNT_LO            6
`define MAC_DOM_CPU1          5
`define MAC_DOM_CPU2          4
`define MAC_DOM_CPU3          3

`define MAC_CPU_ADDR_BASE     8'h30
`define MAC_SEL_MAX           4'h9
`define MAC_NUM_CHAN          10
`define MAC_MEAN_COUNT        16

`define MAC_CLK_PERIOD_NS     5
`define MAC_CONV_TIME_NS      700000
`define MAC_CONV_CYCLES       (`MAC_CONV_TIME_NS / `MAC_CLK_PERIOD_NS)

`endif

// ---- mac_pkg.sv ----
// Types shared by the monitor converter and CPU poll control
`default_nettype none
package mac_pkg;
    typedef enum {P_IDLE, P_REQ, P_WAIT} mac_poll_state_t;
    typedef logic [3:0] mac_chan_t;
    typedef logic [9:0] mac_code_t;
endpackage : mac_pkg
`default_nettype wire

// ---- mac_averager.sv ----
// Averager of a run of conversions, or pass-through when averaging is off
`timescale 1ns/100ps
`default_nettype none

module mac_averager #(
    parameter int W = 10,
    parameter int N = 16
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Control
    input  wire logic         clear,
    input  wire logic         averaging_off,
    // Samples in
    input  wire logic         sample_valid,
    input  wire logic [W-1:0] sample,
    // Result out
    output var  logic         result_valid,
    output var  logic [W-1:0] result
);
    localparam int CW = $clog2(N);
    localparam int SW = W + CW;

    logic [SW-1:0] sum_reg;
    logic [CW-1:0] cnt_reg;
    wire  [SW-1:0] sum_next = sum_reg + SW'(sample);
    wire           last     = (cnt_reg == CW'(N - 1));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sum_reg      <= '0;
            cnt_reg      <= '0;
            result_valid <= 1'b0;
            result       <= '0;
        end else if (clear) begin
            sum_reg      <= '0;
            cnt_reg      <= '0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= sample_valid && (averaging_off || last);
            if (sample_valid && averaging_off) begin
                result  <= sample;
                cnt_reg <= '0;
                sum_reg <= '0;
            end else if (sample_valid && last) begin
                // Power-of-two count: the top bits are the mean
                result  <= sum_next[SW-1 -: W];
                cnt_reg <= '0;
                sum_reg <= '0;
            end else if (sample_valid) begin
                sum_reg <= sum_next;
                cnt_reg <= cnt_reg + CW'(1);
            end
        end
    end

    a_mean_run_len: assert property (@(posedge ref_clk) disable iff (rst)
        result_valid && !$past(averaging_off) && !$past(clear) |-> $past(cnt_reg) == CW'(N - 1))
        else $error("averaged result after wrong sample count");

endmodule : mac_averager
`default_nettype wire

// ---- mac_cpu_model.sv ----
// Far-side model: converter answering starts and CPUs answering thermal polls
`timescale 1ns/100ps
`default_nettype none

module mac_cpu_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Converter
    input  wire logic       adc_start,
    input  wire logic [3:0] adc_channel,
    output var  logic       adc_done,
    output var  logic [9:0] adc_code,
    // CPU thermal bus
    input  wire logic       poll_req,
    input  wire logic [7:0] poll_addr,
    input  wire logic       poll_domain,
    output var  logic       poll_done,
    output var  logic [7:0] poll_temp
);
    logic [9:0] code_tab [16];
    logic [7:0] temp_tab [4][2];
    logic [3:0] conv_ch;
    logic [2:0] cpu_dom;
    int         adc_wait;
    int         poll_wait;

    initial begin
        code_tab = '{default: 10'h000};
        temp_tab = '{default: 8'h00};
        adc_done = 1'b0;
        adc_code = 10'h155;
        poll_done = 1'b0;
        poll_temp = 8'h5a;
        adc_wait = 0;
        poll_wait = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Latch each request, answer after a random delay well inside one period
    always @(posedge ref_clk) begin
        if (adc_start && !rst) begin
            conv_ch <= adc_channel;
            adc_wait <= 1 + $urandom % 10;
        end else if (adc_wait > 0) begin
            adc_wait <= adc_wait - 1;
        end
        if (poll_req && !rst) begin
            cpu_dom <= {poll_addr[1:0], poll_domain};
            poll_wait <= 1 + $urandom % 6;
        end else if (poll_wait > 0) begin
            poll_wait <= poll_wait - 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Released data lines toggle so a stale value never passes for an answer
    always @(negedge ref_clk) begin
        adc_done <= (adc_wait == 1);
        adc_code <= (adc_wait == 1) ? code_tab[conv_ch] : ~adc_code;
        poll_done <= (poll_wait == 1);
        poll_temp <= (poll_wait == 1) ? temp_tab[cpu_dom[2:1]][cpu_dom[0]] : ~poll_temp;
    end
endmodule : mac_cpu_model

`default_nettype wire

// ---- mac_monitor_ctrl_bench.sv ----
// Self-checking bench: registers, converter sequencing and CPU polling
`timescale 1ns/100ps
`default_nettype none

module mac_monitor_ctrl_bench;
    localparam int CONV = 20;

    logic       ref_clk;
    logic       rst;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       adc_start;
    logic [3:0] adc_channel;
    logic [3:0] atten_bypass;
    logic       adc_done;
    logic [9:0] adc_code;
    logic       poll_req;
    logic [7:0] poll_addr;
    logic       poll_domain;
    logic       poll_done;
    logic [7:0] poll_temp;
    logic [7:0] rq [$];
    logic [9:0] pq [$];
    logic       rd_seen;
    logic       ch_on;
    logic [3:0] exp_ch;
    int         gap = 1000;
    int         fails = 0;
    int         cmp_count = 0;

    mac_monitor_ctrl #(.CONV_CYCLES(CONV)) i_mac_monitor_ctrl (
        .ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .adc_start, .adc_channel, .atten_bypass, .adc_done, .adc_code,
        .poll_req, .poll_addr, .poll_domain, .poll_done, .poll_temp
    );
    mac_cpu_model i_mac_cpu_model (
        .ref_clk, .rst, .adc_start, .adc_channel, .adc_done, .adc_code,
        .poll_req, .poll_addr, .poll_domain, .poll_done, .poll_temp
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        rq.push_back(e);
        @(negedge ref_clk);
        reg_rd = 1'b0;
    endtask : rd

    // Extra cycles let the stored reading settle before it is read
    task automatic wait_conv(input int n);
        for (int k = 0; k < 100 * CONV && n > 0; k++) begin
            @(negedge ref_clk);
            if (adc_done) n--;
        end
        if (n > 0) fails++;
        repeat (3) @(negedge ref_clk);
    endtask : wait_conv

    task automatic wait_start;
        for (int k = 0; k < 2 * CONV && !adc_start; k++) @(negedge ref_clk);
        if (adc_start !== 1'b1) fails++;
    endtask : wait_start

    // Writing just after a start keeps the channel change clear of the next one
    task automatic sel(input logic [7:0] a, input logic [7:0] d, input logic [3:0] c);
        wait_start();
        ch_on = 1'b0;
        wr(a, d);
        exp_ch = c;
        ch_on = 1'b1;
    endtask : sel

    task automatic test_done;
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor: each result is compared with the oldest note
    always @(posedge ref_clk) rd_seen <= reg_rd;

    always @(negedge ref_clk) begin
        gap = gap + 1;
        if (rd_seen === 1'b1) check({2'b00, reg_rdata}, {2'b00, rq.pop_front()});
        if (poll_req === 1'b1)
            check({1'b0, poll_addr, poll_domain}, pq.size() ? pq.pop_front() : 10'h3ff);
        if (adc_start === 1'b1) begin
            if (gap < 1000) check(10'(gap), 10'(CONV));
            if (ch_on) check({6'h00, adc_channel}, {6'h00, exp_ch});
            gap = 0;
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic [9:0] old;
        logic [7:0] hot;
        logic [7:0] rd_ofs [10];
        logic [7:0] rd_cpu [4];
        rd_ofs = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h00, 8'h00, 8'h1e, 8'h1d};
        rd_cpu = '{8'h33, 8'h1a, 8'h1b, 8'h1c};
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ch_on = 1'b0;
        exp_ch = 4'h0;
        void'($urandom(32'h0cd74e73));
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        // Reset values, unmapped and read-only places
        rd(8'h7d, 8'h00);
        rd(8'h55, 8'h00);
        rd(8'h88, 8'h00);
        rd(8'hff, 8'h00);
        wr(8'h20, 8'haa);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 6; i++) begin
            d = (i < 4) ? (8'h10 << i) : 8'($urandom);
            wr(8'h7d, d);
            check({6'h00, atten_bypass}, {6'h00, d[7:4]});
            rd(8'h7d, d);
        end
        // Single channel, averaging off, every select code
        for (int c = 0; c < 10; c++)
            i_mac_cpu_model.code_tab[c] = (c == 0) ? 10'h3ff : (c == 4) ? 10'h300 : 10'($urandom);
        wr(8'h73, 8'h50);
        for (int c = 0; c < 10; c++) begin
            d = {4'(c), 4'($urandom)};
            sel(8'h55, d, 4'(c));
            wait_conv(2);
            rd(8'h55, d);
            if (c != 6 && c != 7) rd(rd_ofs[c], i_mac_cpu_model.code_tab[c][9:2]);
        end
        wr(8'h55, 8'hb3);
        wait_conv(2);
        rd(8'h55, 8'hb3);
        // Sixteen conversions before the reading moves
        sel(8'h55, 8'h30, 4'h3);
        wait_conv(2);
        old = i_mac_cpu_model.code_tab[3];
        wr(8'h73, 8'h40);
        i_mac_cpu_model.code_tab[3] = 10'h200;
        wait_conv(15);
        rd(8'h23, old[9:2]);
        wait_conv(1);
        rd(8'h23, 8'h80);
        sel(8'h73, 8'h10, 4'h0);
        @(negedge ref_clk);
        wait_start();
        @(negedge ref_clk);
        ch_on = 1'b0;
        // CPU polling: four CPUs, two of them with two domains
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 2; j++)
                i_mac_cpu_model.temp_tab[i][j] = 8'(-($urandom % 100));
        wr(8'h36, 8'h08);
        wr(8'h88, 8'hd0);
        repeat (2) begin
            for (int i = 0; i < 4; i++) begin
                pq.push_back({1'b0, 8'h30 + 8'(i), 1'b0});
                if (i % 2 == 0) pq.push_back({1'b0, 8'h30 + 8'(i), 1'b1});
            end
        end
        wr(8'h40, 8'h10);
        for (int k = 0; k < 100 * CONV && pq.size() > 5; k++) @(negedge ref_clk);
        if (pq.size() > 5) fails++;
        wr(8'h40, 8'h00);
        for (int i = 0; i < 4; i++) begin
            hot = i_mac_cpu_model.temp_tab[i][0];
            if (i % 2 == 0 && $signed(i_mac_cpu_model.temp_tab[i][1]) > $signed(hot))
                hot = i_mac_cpu_model.temp_tab[i][1];
            rd(rd_cpu[i], hot);
        end
        repeat (50) @(negedge ref_clk);
        pq.delete();
        // Any poll from here on meets an empty note queue
        repeat (100) @(negedge ref_clk);
        test_done();
    end
endmodule : mac_monitor_ctrl_bench

`default_nettype wire
